// *** design/spm_port.sv ***
`timescale 1ns/100ps

// Stream buffer between the producer and the shift register
module spm_fifo
  import spm_pkg::*;
#(
  parameter int WIDTH = BYTE_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic full;
  logic empty;
  logic push;
  logic pop;

  // Extra pointer bit tells full from empty
  assign empty = (wr_q == rd_q);
  assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign push = in_valid && !full;
  assign pop = out_ready && !empty;
  assign out_data = mem_q[rd_q[AW-1:0]];

  // Storage
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge mclk) begin
    if (srst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

// What this block does
// - MOSI output as master, input as slave
// - Bytes shift most significant bit first
// - Master drives shift register MSB on MOSI
// - MISO input as master, output as slave
// - MISO floats when disabled or unselected
// - Three-wire slave always drives MISO from MSB
// - Serial clock generated only as master
// - Unselected four-wire slave ignores serial clock
// - Mode 00: three-wire, slave always selected
// - Mode 01: select input low selects slave
// - Select falling edge in mode 01 drops master
// - Mode 1x drives select pin at low bit
// - Select pin routed except in three-wire mode
module spm_port
  import spm_pkg::*;
#(
  parameter int HALF_CYC = SCK_HALF_CYC,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic srst,
  input wire spm_ctrl_s ctrl,
  input wire logic fault_clear,
  output logic mode_fault,
  output logic nss_routed,
  input wire logic [BYTE_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [BYTE_W-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic rx_overrun,
  input wire spm_pins_s pin_in,
  output spm_pins_s pin_out,
  output spm_pins_s pin_oe
);
  spm_pins_s meta_q;
  spm_pins_s sync_q;
  logic sck_p_q;
  logic nss_p_q;
  logic fault_q;
  spm_state_e state_q;
  logic [$clog2(HALF_CYC+1)-1:0] div_q;
  logic tick;
  logic sck_q;
  logic [BYTE_W-1:0] shreg_q;
  logic [BIT_CNT_W-1:0] bitcnt_q;
  logic in_bit_q;
  logic loaded_q;
  logic master_active;
  logic slave_active;
  logic selected;
  logic sck_rise;
  logic sck_fall;
  logic nss_fall;
  logic m_start;
  logic m_done;
  logic s_done;
  logic s_load;
  logic pop;
  logic [BYTE_W-1:0] fifo_data;
  logic fifo_valid;
  logic [1:0] mode;

  assign mode = ctrl.select_mode_field;

  // Two-flop synchronisers on every pin input
  always_ff @(posedge mclk) begin
    if (srst) begin
      // Select idles high; a low reset value would fake a falling edge
      meta_q <= '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, nss: 1'b1};
      sync_q <= '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, nss: 1'b1};
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  // Delayed copies for edge detection, read from the second flop only
  always_ff @(posedge mclk) begin
    if (srst) begin
      sck_p_q <= 1'b0;
      nss_p_q <= 1'b1;
    end else begin
      sck_p_q <= sync_q.sck;
      nss_p_q <= sync_q.nss;
    end
  end

  assign sck_rise = sync_q.sck && !sck_p_q;
  assign sck_fall = !sync_q.sck && sck_p_q;
  assign nss_fall = nss_p_q && !sync_q.nss;

  // Roles; a slave set to mode 1x is misconfigured and stays deselected
  assign master_active = ctrl.en && ctrl.master && !fault_q;
  assign slave_active = ctrl.en && !ctrl.master;
  assign selected = slave_active &&
    ((mode == SEL_3WIRE) ||
     (mode == SEL_4W_SLAVE && !sync_q.nss));

  // Another master pulling select low takes the bus from us
  always_ff @(posedge mclk) begin
    if (srst) begin
      fault_q <= 1'b0;
    end else if (ctrl.en && ctrl.master && mode == SEL_4W_SLAVE &&
                 nss_fall) begin
      fault_q <= 1'b1;
    end else if (fault_clear || !ctrl.en) begin
      fault_q <= 1'b0;
    end
  end
  assign mode_fault = fault_q;

  // Half-period divider, runs only during a master byte
  always_ff @(posedge mclk) begin
    if (srst || state_q == SPM_IDLE) begin
      div_q <= '0;
    end else if (tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end
  assign tick = (div_q == ($clog2(HALF_CYC+1))'(HALF_CYC - 1));

  assign m_start = master_active && state_q == SPM_IDLE && fifo_valid;
  assign m_done = state_q == SPM_TRAIL && tick && bitcnt_q == BIT_LAST;

  // Master sequencer: clock idles low, data sampled on the rising edge
  always_ff @(posedge mclk) begin
    if (srst || !master_active) begin
      state_q <= SPM_IDLE;
      sck_q <= 1'b0;
    end else begin
      case (state_q)
        SPM_IDLE: begin
          if (m_start) begin
            state_q <= SPM_LEAD;
          end
        end
        SPM_LEAD: begin
          if (tick) begin
            sck_q <= 1'b1;
            state_q <= SPM_TRAIL;
          end
        end
        SPM_TRAIL: begin
          if (tick) begin
            sck_q <= 1'b0;
            state_q <= (bitcnt_q == BIT_LAST) ? SPM_IDLE : SPM_LEAD;
          end
        end
        default: begin
          state_q <= SPM_IDLE;
          sck_q <= 1'b0;
        end
      endcase
    end
  end

  // Slave preloads its reply at a byte boundary; empty buffer sends the register as left, zeros after reset or a slave byte
  assign s_load = selected && bitcnt_q == BIT_FIRST && !loaded_q &&
    fifo_valid;
  assign s_done = selected && sck_fall && bitcnt_q == BIT_LAST;
  assign pop = m_start || s_load;

  always_ff @(posedge mclk) begin
    if (srst || !selected || s_done) begin
      loaded_q <= 1'b0;
    end else if (s_load) begin
      loaded_q <= 1'b1;
    end
  end

  // Shift register and bit counter shared by both roles
  always_ff @(posedge mclk) begin
    if (srst) begin
      shreg_q <= BYTE_IDLE;
      bitcnt_q <= BIT_FIRST;
      in_bit_q <= 1'b0;
    end else if (master_active) begin
      if (m_start) begin
        shreg_q <= fifo_data;
        bitcnt_q <= BIT_FIRST;
      end else if (state_q == SPM_LEAD && tick) begin
        in_bit_q <= sync_q.miso;
      end else if (state_q == SPM_TRAIL && tick) begin
        shreg_q <= {shreg_q[BYTE_MSB-1:0], in_bit_q};
        bitcnt_q <= bitcnt_q + 1'b1;
      end
    end else if (!selected) begin
      bitcnt_q <= BIT_FIRST;
    end else if (s_load) begin
      shreg_q <= fifo_data;
    end else if (sck_rise) begin
      in_bit_q <= sync_q.mosi;
    end else if (sck_fall) begin
      shreg_q <= s_done ? BYTE_IDLE :
        {shreg_q[BYTE_MSB-1:0], in_bit_q};
      bitcnt_q <= bitcnt_q + 1'b1;
    end
  end

  // Received byte holding register; an unread byte is overwritten
  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_data <= BYTE_IDLE;
      rx_valid <= 1'b0;
      rx_overrun <= 1'b0;
    end else begin
      if (m_done || s_done) begin
        rx_data <= {shreg_q[BYTE_MSB-1:0], in_bit_q};
        rx_valid <= 1'b1;
        rx_overrun <= rx_overrun || (rx_valid && !rx_ready);
      end else if (rx_ready) begin
        rx_valid <= 1'b0;
      end
      if (fault_clear && !(m_done || s_done)) begin
        rx_overrun <= 1'b0;
      end
    end
  end

  spm_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(DEPTH)
  ) u_tx_fifo (
    .mclk(mclk),
    .srst(srst),
    .in_data(tx_data),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(pop)
  );

  // Pin drive
  assign pin_out.mosi = shreg_q[BYTE_MSB];
  assign pin_oe.mosi = master_active;
  assign pin_out.miso = shreg_q[BYTE_MSB];
  assign pin_oe.miso = selected;
  assign pin_out.sck = sck_q;
  assign pin_oe.sck = master_active;
  assign pin_out.nss = mode[SEL_LEVEL_POS];
  assign pin_oe.nss = ctrl.en && mode[SEL_HIGH_POS];
  assign nss_routed = (mode != SEL_3WIRE);

  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  AST_MSB_FIRST: assert property (
    m_start |=> pin_out.mosi == $past(fifo_data[BYTE_MSB]))
    else $error("master did not present the byte MSB first");

  AST_MOSI_DIR: assert property (
    (ctrl.en && !ctrl.master) |-> !pin_oe.mosi)
    else $error("slave drove the MOSI line");

  AST_MISO_HIZ: assert property (
    (!ctrl.en || (mode == SEL_4W_SLAVE && sync_q.nss)) |-> !pin_oe.miso)
    else $error("MISO driven while disabled or unselected");

  AST_3W_DRIVE: assert property (
    (slave_active && mode == SEL_3WIRE) |->
      pin_oe.miso && pin_out.miso == shreg_q[BYTE_MSB])
    else $error("three-wire slave not driving MISO from MSB");

  AST_SCK_MASTER: assert property (
    $rose(sck_q) |-> $past(master_active) && $past(state_q == SPM_LEAD))
    else $error("serial clock rose outside a master byte");

  AST_SCK_IGNORED: assert property (
    (slave_active && mode == SEL_4W_SLAVE && sync_q.nss)
      |=> bitcnt_q == BIT_FIRST && !s_done)
    else $error("unselected slave counted clock edges");

  AST_FAULT: assert property (
    (ctrl.en && ctrl.master && mode == SEL_4W_SLAVE && nss_fall &&
     !fault_clear) |=> fault_q && !pin_oe.sck && state_q == SPM_IDLE)
    else $error("select fall did not remove master function");

  AST_NSS_OUT: assert property (
    (ctrl.en && mode[SEL_HIGH_POS]) |->
      pin_oe.nss && pin_out.nss == mode[SEL_LEVEL_POS] && nss_routed)
    else $error("select output level or routing wrong");

  AST_BYTE_DONE: assert property (
    m_done |=> rx_valid && rx_data == $past({shreg_q[BYTE_MSB-1:0],
      in_bit_q}))
    else $error("received byte not delivered after eighth bit");
endmodule

// *** shared/spm_pkg.sv ***
package spm_pkg;

  // Clock and link timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int SCK_HALF_NS = 100;
  localparam int SCK_HALF_CYC =
    (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Byte framing
  localparam int BYTE_W = 8;
  localparam int BYTE_MSB = BYTE_W - 1;
  localparam int BIT_CNT_W = 3;
  localparam logic [BIT_CNT_W-1:0] BIT_LAST = 3'h7;
  localparam logic [BIT_CNT_W-1:0] BIT_FIRST = 3'h0;
  localparam logic [BYTE_W-1:0] BYTE_IDLE = 8'h00;
  localparam int FIFO_DEPTH = 16;

  // Select-mode field encodings and bit positions
  localparam logic [1:0] SEL_3WIRE = 2'h0;
  localparam logic [1:0] SEL_4W_SLAVE = 2'h1;
  localparam int SEL_HIGH_POS = 1;
  localparam int SEL_LEVEL_POS = 0;

  // Master sequencer states
  typedef enum logic [1:0] {
    SPM_IDLE  = 2'b00,
    SPM_LEAD  = 2'b01,
    SPM_TRAIL = 2'b10
  } spm_state_e;

  // Static port configuration
  typedef struct packed {
    logic en;
    logic master;
    logic [1:0] select_mode_field;
  } spm_ctrl_s;

  // Pin levels seen from outside
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic nss;
  } spm_pins_s;

endpackage

// *** verif/spm_peer.sv ***
`timescale 1ns/100ps

// Far device: a slave that always answers, or a master that frames
// on request, with the port as the slave while it frames
module spm_peer
  import spm_pkg::*;
(
  input wire spm_pins_s pin,
  output logic sck,
  output logic mosi,
  output logic miso,
  output logic nss
);
  logic [BYTE_W-1:0] s_tx = BYTE_IDLE;
  logic [BYTE_W-1:0] s_rx;
  int s_cnt = 0;

  initial begin
    sck = 1'b0;
    mosi = 1'b1;
    nss = 1'b1;
  end

  // Slave answer MSB first; spent bits come back inverted so they move
  assign miso = s_tx[BYTE_MSB];
  always @(posedge pin.sck) s_rx <= {s_rx[BYTE_MSB-1:0], pin.mosi};
  always @(negedge pin.sck) begin
    s_tx <= {s_tx[BYTE_MSB-1:0], ~s_tx[BYTE_MSB]};
    s_cnt <= s_cnt + 1;
  end

  // Master frame, 200 ns clock that stands low outside the frame
  task automatic frame(input logic [BYTE_W-1:0] tx, input logic sel,
                       output logic [BYTE_W-1:0] rx);
    #7 nss = ~sel;
    #150;
    for (int i = BYTE_MSB; i >= 0; i--) begin
      mosi = tx[i];
      #100 sck = 1'b1;
      rx = {rx[BYTE_MSB-1:0], pin.miso};
      #100 sck = 1'b0;
    end
    #150 nss = 1'b1;
    mosi = ~mosi;
  endtask
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/100ps

module testbench;
  import spm_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic fault_clear = 1'b0;
  spm_ctrl_s ctrl = '0;
  logic [BYTE_W-1:0] tx_data = BYTE_IDLE;
  logic tx_valid = 1'b0;
  logic rx_ready = 1'b0;
  logic [BYTE_W-1:0] rx_data;
  logic [BYTE_W-1:0] got;
  logic tx_ready, rx_valid, rx_overrun, mode_fault, nss_routed;
  logic psck, pmosi, pmiso, pnss;
  spm_pins_s p_in, p_out, p_oe;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int start;

  // 40 MHz system clock
  always #12.5 mclk = ~mclk;

  // Each pin shows its driver; the peer fills the pins left undriven
  assign p_in = (p_out & p_oe) | ({psck, pmosi, pmiso, pnss} & ~p_oe);

  spm_port #(.HALF_CYC(4), .DEPTH(FIFO_DEPTH)) dut (
    .mclk(mclk), .srst(srst), .ctrl(ctrl), .fault_clear(fault_clear),
    .mode_fault(mode_fault), .nss_routed(nss_routed),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_overrun(rx_overrun), .pin_in(p_in), .pin_out(p_out), .pin_oe(p_oe)
  );
  spm_peer peer (.pin(p_in), .sck(psck), .mosi(pmosi), .miso(pmiso),
    .nss(pnss));

  task automatic chk(input logic [BYTE_W-1:0] g, input logic [BYTE_W-1:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // New configuration at an edge, then time for the synchronisers
  task automatic set(input logic m, input logic [1:0] md);
    @(posedge mclk) ctrl <= '{en: 1'b1, master: m, select_mode_field: md};
    repeat (4) @(negedge mclk);
  endtask

  // Offer a byte; returns before the edge that takes it
  task automatic push(input logic [BYTE_W-1:0] b);
    logic r;
    @(posedge mclk) tx_data <= b;
    tx_valid <= 1'b1;
    do begin
      @(negedge mclk) r = tx_ready;
    end while (!r);
  endtask

  // Wait for a received byte, judge it, then consume it
  task automatic take(input logic [BYTE_W-1:0] e);
    for (int i = 0; i < 2000 && rx_valid !== 1'b1; i++) @(negedge mclk);
    chk(rx_valid, 1'b1);
    chk(rx_data, e);
    @(posedge mclk) rx_ready <= 1'b1;
    @(posedge mclk) rx_ready <= 1'b0;
    @(negedge mclk);
  endtask

  // Disabled port after reset drives no pin
  task automatic t_idle();
    chk(p_oe, 4'h0);
    chk(tx_ready, 1'b1);
    chk(mode_fault, 1'b0);
  endtask

  // Master in mode 1x, two bytes back to back
  task automatic t_master();
    set(1'b1, 2'h2);
    chk(p_oe, 4'hd);
    chk(p_out.nss, 1'b0);
    chk(nss_routed, 1'b1);
    set(1'b1, 2'h3);
    chk(p_out.nss, 1'b1);
    peer.s_tx = 8'hc3;
    push(8'ha5);
    push(8'h5e);
    @(posedge mclk) tx_valid <= 1'b0;
    take(8'hc3);
    chk(peer.s_rx, 8'ha5);
    take(~8'hc3);
    chk(peer.s_rx, 8'h5e);
  endtask

  // Three-wire slave: always selected, MISO always driven
  task automatic t_slave3();
    set(1'b0, 2'h0);
    chk(p_oe, 4'h2);
    chk(nss_routed, 1'b0);
    push(8'h96);
    @(posedge mclk) tx_valid <= 1'b0;
    peer.frame(8'h5a, 1'b0, got);
    chk(got, 8'h96);
    take(8'h5a);
  endtask

  // Four-wire slave; the FIFO fills while deselected, drains as master
  // with the consumer stalled, so the receive side overruns
  task automatic t_slave4();
    set(1'b0, 2'h1);
    chk(p_oe, 4'h0);
    chk(nss_routed, 1'b1);
    peer.frame(8'hff, 1'b0, got);
    repeat (4) @(negedge mclk);
    chk(rx_valid, 1'b0);
    for (int i = 0; i < FIFO_DEPTH; i++) push(8'(i) * 8'h11);
    @(posedge mclk) tx_data <= 8'hee;
    repeat (3) @(negedge mclk);
    chk(tx_ready, 1'b0);
    @(posedge mclk) tx_valid <= 1'b0;
    peer.frame(8'h81, 1'b1, got);
    chk(got, 8'h00);
    take(8'h81);
    start = peer.s_cnt;
    set(1'b1, 2'h3);
    // The slave preloads the next byte while still selected and the
    // deselect drops it, so 14 bytes (112 clocks) are left for the master
    for (int i = 0; i < 3000 && peer.s_cnt < start + 112; i++)
      @(negedge mclk);
    repeat (100) @(negedge mclk);
    chk(8'(peer.s_cnt - start), 8'h70);
    chk(peer.s_rx, 8'hff);
    chk(tx_ready, 1'b1);
    chk(rx_overrun, 1'b1);
  endtask

  // Multi-master: select falls while master, so mastership is lost
  task automatic t_fault();
    set(1'b1, 2'h1);
    chk(mode_fault, 1'b0);
    peer.nss = 1'b0;
    repeat (5) @(negedge mclk);
    chk(mode_fault, 1'b1);
    chk(p_oe.sck, 1'b0);
    chk(p_oe.mosi, 1'b0);
    @(posedge mclk) fault_clear <= 1'b1;
    @(posedge mclk) fault_clear <= 1'b0;
    @(negedge mclk);
    chk(mode_fault, 1'b0);
    chk(rx_overrun, 1'b0);
    peer.nss = 1'b1;
  endtask

  // Reset, scenarios, verdict
  initial begin
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    @(negedge mclk);
    t_idle();
    t_master();
    t_slave3();
    t_slave4();
    t_fault();
    tally_and_finish();
  end

  // Cut a hang short
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
endmodule
